//--- deepc_pkg.sv
// Purpose: shared constants for the data eeprom program/erase control block
// Assumes: 16-bit register port, 100 MHz system clock
// Notes:   offsets and cycle times are chosen values held here once
package deepc_pkg;
	localparam logic [1:0]  ADDR_CONTROL     = 2'h0;
	localparam logic [1:0]  ADDR_KEY         = 2'h1;
	localparam logic [1:0]  ADDR_TARGET_LOW  = 2'h2;
	localparam logic [1:0]  ADDR_TARGET_HIGH = 2'h3;
	localparam logic [15:0] CONTROL_RESET    = 16'h0000;
	localparam logic [15:0] CONTROL_RW_MASK  = 16'h507F;
	localparam logic [7:0]  KEY_FIRST        = 8'h55;
	localparam logic [7:0]  KEY_SECOND       = 8'hAA;
	localparam int          BIT_START        = 15;
	localparam int          BIT_PERMIT       = 14;
	localparam int          BIT_ABORTED      = 13;
	localparam int          BIT_SKIP_ERASE   = 12;
	localparam int          BIT_ERASE_SEL    = 6;
	localparam logic [5:0]  CMD_ERASE_8      = 6'h1A;
	localparam logic [5:0]  CMD_ERASE_4      = 6'h19;
	localparam logic [5:0]  CMD_ERASE_1      = 6'h18;
	localparam logic [3:0]  CMD_BULK_HI      = 4'h4;
	localparam logic [3:0]  CMD_WRITE_HI     = 4'h2;
	localparam int          WORDS            = 256;
	localparam logic [23:0] EEPROM_BASE      = 24'h7F_FE00;
	localparam int          CLK_MHZ          = 100;
	localparam int          ERASE_TIME_US    = 2;
	localparam int          WRITE_TIME_US    = 2;
	localparam int          ERASE_CYCLES     = ERASE_TIME_US * CLK_MHZ;
	localparam int          WRITE_CYCLES     = WRITE_TIME_US * CLK_MHZ;
	typedef enum logic [1:0] {UNLOCK_IDLE, UNLOCK_GOT_FIRST, UNLOCK_OPEN} deepc_unlock_type;
	typedef enum logic [1:0] {OP_IDLE, OP_ERASE, OP_WRITE} deepc_op_type;
endpackage

//--- deepc_ctrl.sv
// Purpose: data eeprom program/erase sequencer with unlock guard
// Assumes: processor writes registers over a plain strobe port, one clock
// Notes:   the array itself lies outside; this drives its erase/program pulses
// Function
// - start bit settable only in the one cycle after unlock; bits 14, 12 and 6..0 writable while idle
// - key register write-only, guards against accidents
// - start bit settable only, hardware clears done
// - permit bit enables, cleared on finish
// - aborted flag set on reset mid-cycle
// - skip-preerase bit omits automatic erase before write
// - control bits 11..7 read zero
// - erase-select picks erase or write
// - erase 8, 4, 1 words by command
// - 0100xx erases whole eeprom
// - 0010xx programs one word
// - processor never stalled during cycle
// - 256 words at 7FFE00h, 16 bits
// - done flag raised when cycle completes
// - target address captured from table write
//
// The implementer's own choices: the address-and-strobe port and the address map.
module deepc_ctrl
	import deepc_pkg::*;
#(
	parameter int ERASE_COUNT = deepc_pkg::ERASE_CYCLES,
	parameter int WRITE_COUNT = deepc_pkg::WRITE_CYCLES
)
(
	input  wire logic        sys_clk,        // system clock
	input  wire logic        reset,          // async active-high reset
	input  wire logic        abort_reset,    // master clear or watchdog reset event, async
	input  wire logic [1:0]  reg_addr,       // register index
	input  wire logic [15:0] reg_wdata,      // write data
	input  wire logic        reg_wr,         // write strobe
	input  wire logic        reg_rd,         // read strobe
	output logic      [15:0] reg_rdata,      // read data, cycle after strobe
	input  wire logic        tblwt_valid,    // table write executed
	input  wire logic [23:0] tblwt_addr,     // effective address of table write
	output logic             cycle_done_irq_flag, // one-cycle done pulse
	output logic             array_erase,    // erase pulse level to array
	output logic             array_program,  // program level to array
	output logic             array_bulk,     // whole-array select
	output logic      [7:0]  array_word,     // first word index
	output logic      [3:0]  array_count,    // words affected
	output logic             busy            // cycle running
);
	import deepc_pkg::*;

	deepc_unlock_type unlock_ff, nxt_unlock;
	deepc_op_type     op_ff, nxt_op;
	logic [15:0] ctrl_ff, nxt_ctrl;
	logic [23:0] target_ff;
	logic [15:0] timer_ff, nxt_timer;
	logic        write_pending_ff, nxt_write_pending;
	logic [15:0] rdata_ff;
	logic        done_ff, erase_ff, program_ff, bulk_ff;
	logic [7:0]  word_ff;
	logic [3:0]  count_ff;
	logic        abort_meta_ff, abort_sync_ff;
	logic        busy_ff;

	// decode of command field into erase word count; zero for any other command, bulk and write included
	function automatic logic [3:0] erase_words(input logic [5:0] cmd);
		if (cmd == CMD_ERASE_8)
			erase_words = 4'h8;
		else if (cmd == CMD_ERASE_4)
			erase_words = 4'h4;
		else if (cmd == CMD_ERASE_1)
			erase_words = 4'h1;
		else
			erase_words = 4'h0;
	endfunction

	wire wr_key      = reg_wr && (reg_addr == ADDR_KEY);
	wire wr_ctrl     = reg_wr && (reg_addr == ADDR_CONTROL);
	wire window_open = (unlock_ff == UNLOCK_OPEN);
	wire [5:0] cmd   = ctrl_ff[5:0];
	wire is_bulk     = cmd[5:2] == CMD_BULK_HI;
	wire is_write    = cmd[5:2] == CMD_WRITE_HI;
	wire [3:0] n_words = erase_words(cmd);
	wire start_req   = wr_ctrl && window_open && reg_wdata[BIT_START] && !ctrl_ff[BIT_START];
	wire permit_now  = reg_wdata[BIT_PERMIT];
	wire erase_sel   = reg_wdata[BIT_ERASE_SEL];
	wire [5:0] new_cmd = reg_wdata[5:0];
	wire legal_start = start_req && permit_now &&
		(erase_sel ? ((erase_words(new_cmd) != 4'h0) || (new_cmd[5:2] == CMD_BULK_HI))
			: (new_cmd[5:2] == CMD_WRITE_HI));
	wire timer_end   = (timer_ff == 16'h0000);
	wire in_range    = target_ff[23:9] == EEPROM_BASE[23:9];

	// unlock sequencer: any other write drops back to idle
	always_comb
	begin
		nxt_unlock = unlock_ff;
		if (unlock_ff == UNLOCK_OPEN)
			nxt_unlock = UNLOCK_IDLE;
		if (wr_key)
		begin
			if (reg_wdata[7:0] == KEY_FIRST)
				nxt_unlock = UNLOCK_GOT_FIRST;
			else if (reg_wdata[7:0] == KEY_SECOND && unlock_ff == UNLOCK_GOT_FIRST)
				nxt_unlock = UNLOCK_OPEN;
			else
				nxt_unlock = UNLOCK_IDLE;
		end
		else if (reg_wr && unlock_ff == UNLOCK_GOT_FIRST)
			nxt_unlock = UNLOCK_IDLE;
	end

	// control register and operation sequencer
	always_comb
	begin
		nxt_ctrl          = ctrl_ff;
		nxt_op            = op_ff;
		nxt_timer         = timer_ff;
		nxt_write_pending = write_pending_ff;
		if (wr_ctrl && !ctrl_ff[BIT_START])
		begin
			// configuration bits writable while idle; start bit set only by an unlocked start request
			nxt_ctrl = (reg_wdata & CONTROL_RW_MASK) | (ctrl_ff & ~CONTROL_RW_MASK);
			nxt_ctrl[BIT_START] = 1'b0;
			if (start_req)
			begin
				nxt_ctrl[BIT_START]   = 1'b1;
				nxt_ctrl[BIT_ABORTED] = !legal_start;
			end
		end
		case (op_ff)
			OP_IDLE:
			begin
				if (ctrl_ff[BIT_START])
				begin
					if (!ctrl_ff[BIT_PERMIT] || (n_words == 4'h0 && !is_bulk && !is_write) ||
						(!ctrl_ff[BIT_ERASE_SEL] && !is_write) || (!is_bulk && !in_range))
					begin
						// nothing legal to run: finish at once, flag shows the fault
						nxt_ctrl[BIT_START]   = 1'b0;
						nxt_ctrl[BIT_PERMIT]  = 1'b0;
						nxt_ctrl[BIT_ABORTED] = 1'b1;
					end
					else if (ctrl_ff[BIT_ERASE_SEL] || !ctrl_ff[BIT_SKIP_ERASE])
					begin
						nxt_op            = OP_ERASE;
						nxt_timer         = 16'(ERASE_COUNT - 1);
						nxt_write_pending = !ctrl_ff[BIT_ERASE_SEL];
					end
					else
					begin
						nxt_op    = OP_WRITE;
						nxt_timer = 16'(WRITE_COUNT - 1);
					end
				end
			end
			OP_ERASE:
			begin
				nxt_timer = timer_ff - 16'h0001;
				if (timer_end)
				begin
					if (write_pending_ff)
					begin
						nxt_op            = OP_WRITE;
						nxt_timer         = 16'(WRITE_COUNT - 1);
						nxt_write_pending = 1'b0;
					end
					else
						nxt_op = OP_IDLE;
				end
			end
			OP_WRITE:
			begin
				nxt_timer = timer_ff - 16'h0001;
				if (timer_end)
					nxt_op = OP_IDLE;
			end
			default:
				nxt_op = OP_IDLE;
		endcase
		if (op_ff != OP_IDLE && nxt_op == OP_IDLE)
		begin
			nxt_ctrl[BIT_START]   = 1'b0;
			nxt_ctrl[BIT_PERMIT]  = 1'b0;
			nxt_ctrl[BIT_ABORTED] = 1'b0;
		end
		if (abort_sync_ff && op_ff != OP_IDLE)
		begin
			// reset event mid-cycle kills the operation and sets the aborted flag
			nxt_op                = OP_IDLE;
			nxt_write_pending     = 1'b0;
			nxt_ctrl[BIT_START]   = 1'b0;
			nxt_ctrl[BIT_PERMIT]  = 1'b0;
			nxt_ctrl[BIT_ABORTED] = 1'b1;
		end
	end

	wire finishing = (op_ff != OP_IDLE) && timer_end && !write_pending_ff && !abort_sync_ff;

	// key register reads as zero; it cannot be seen
	wire [15:0] rd_mux = (reg_addr == ADDR_CONTROL)     ? ctrl_ff :
		(reg_addr == ADDR_TARGET_LOW)  ? target_ff[15:0] :
		(reg_addr == ADDR_TARGET_HIGH) ? {8'h00, target_ff[23:16]} :
		16'h0000;

	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			abort_meta_ff <= 1'b0;
			abort_sync_ff <= 1'b0;
		end
		else
		begin
			abort_meta_ff <= abort_reset;
			abort_sync_ff <= abort_meta_ff;
		end
	end

	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
			unlock_ff <= UNLOCK_IDLE;
		else
			unlock_ff <= nxt_unlock;
	end

	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
			op_ff <= OP_IDLE;
		else
			op_ff <= nxt_op;
	end

	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
			ctrl_ff <= CONTROL_RESET;
		else
			ctrl_ff <= nxt_ctrl;
	end

	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
			timer_ff <= 16'h0000;
		else
			timer_ff <= nxt_timer;
	end

	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
			write_pending_ff <= 1'b0;
		else
			write_pending_ff <= nxt_write_pending;
	end

	// address follows the latest table write; frozen while a cycle runs
	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
			target_ff <= 24'h00_0000;
		else if (tblwt_valid && op_ff == OP_IDLE)
			target_ff <= {1'b0, tblwt_addr[22:1], 1'b0};
	end

	// reads never wait, so the processor is not stalled by a running cycle
	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
			rdata_ff <= 16'h0000;
		else if (reg_rd)
			rdata_ff <= rd_mux;
	end

	// array-side outputs are all registered so the array sees no decode glitches
	wire       nxt_done    = finishing;
	wire       nxt_erase   = (nxt_op == OP_ERASE);
	wire       nxt_program = (nxt_op == OP_WRITE);
	wire       nxt_bulk    = (nxt_op != OP_IDLE) && ctrl_ff[BIT_ERASE_SEL] && is_bulk;
	wire [7:0] nxt_word    = target_ff[8:1];
	wire [3:0] nxt_count   = is_write && !ctrl_ff[BIT_ERASE_SEL] ? 4'h1 : n_words;
	wire       nxt_busy    = (nxt_op != OP_IDLE);

	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
			done_ff <= 1'b0;
		else
			done_ff <= nxt_done;
	end

	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
			erase_ff <= 1'b0;
		else
			erase_ff <= nxt_erase;
	end

	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
			program_ff <= 1'b0;
		else
			program_ff <= nxt_program;
	end

	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
			bulk_ff <= 1'b0;
		else
			bulk_ff <= nxt_bulk;
	end

	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
			word_ff <= 8'h00;
		else
			word_ff <= nxt_word;
	end

	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
			count_ff <= 4'h0;
		else
			count_ff <= nxt_count;
	end

	// own flop rather than an or of two, so busy never glitches between phases
	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
			busy_ff <= 1'b0;
		else
			busy_ff <= nxt_busy;
	end

	assign reg_rdata           = rdata_ff;
	assign cycle_done_irq_flag = done_ff;
	assign array_erase         = erase_ff;
	assign array_program       = program_ff;
	assign array_bulk          = bulk_ff;
	assign array_word          = word_ff;
	assign array_count         = count_ff;
	assign busy                = busy_ff;
endmodule

//--- deepc_ctrl_assertions.sv
// Purpose: port-level checks for the eeprom program/erase control block
// Assumes: one sys_clk domain, reset async active high
// Notes:   busy bound is generous so both phases fit at any small count
module deepc_ctrl_assertions
	import deepc_pkg::*;
#(
	parameter int ERASE_COUNT = 4,
	parameter int WRITE_COUNT = 4
)
(
	input wire logic        sys_clk,             // clock
	input wire logic        reset,               // reset
	input wire logic [1:0]  reg_addr,            // index
	input wire logic [15:0] reg_wdata,           // write data
	input wire logic        reg_wr,              // write strobe
	input wire logic        reg_rd,              // read strobe
	input wire logic [15:0] reg_rdata,           // read data
	input wire logic        cycle_done_irq_flag, // done pulse
	input wire logic        array_erase,         // erase phase
	input wire logic        array_program,       // program phase
	input wire logic        array_bulk,          // whole array
	input wire logic [3:0]  array_count,         // word count
	input wire logic        busy                 // running
);
	localparam int BUSY_MAX = 600;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);
	wire logic ctl_wr = reg_wr && reg_addr == ADDR_CONTROL;
	a_rsvd_zero: assert property (reg_rd && reg_addr == ADDR_CONTROL |=> reg_rdata[11:7] == 5'h00)
		else $error("reserved control bits read non-zero");
	a_key_hidden: assert property (reg_rd && reg_addr == ADDR_KEY |=> reg_rdata == 16'h0000)
		else $error("key register readable");
	a_busy_bounded: assert property ($rose(busy) |-> ##[1:BUSY_MAX] !busy)
		else $error("cycle never finished");
	a_done_pulse: assert property (cycle_done_irq_flag |=> !cycle_done_irq_flag)
		else $error("done flag longer than one cycle");
	a_done_after_op: assert property (cycle_done_irq_flag |-> $past(busy) || $past(busy, 2))
		else $error("done without a cycle");
	a_locked_start: assert property (ctl_wr && !busy && !($past(reg_wr) && $past(reg_addr) == ADDR_KEY
		&& $past(reg_wdata[7:0]) == KEY_SECOND) |=> (!busy) [*3])
		else $error("cycle started without unlock");
	a_phase_excl: assert property (!(array_erase && array_program))
		else $error("erase and program together");
	a_erase_count: assert property (array_erase && !array_bulk |-> array_count inside {4'h1, 4'h4, 4'h8})
		else $error("bad erase word count");
	a_prog_one: assert property (array_program |-> array_count == 4'h1 && !array_bulk)
		else $error("program not one word");
	a_bulk_zero: assert property (array_bulk && array_erase |-> array_count == 4'h0)
		else $error("bulk erase with word count");
	c_erase: cover property ($rose(array_erase));
	c_prog: cover property ($rose(array_program));
	c_bulk: cover property (array_bulk && array_erase);
	c_done: cover property (cycle_done_irq_flag);
endmodule
bind deepc_ctrl deepc_ctrl_assertions #(.ERASE_COUNT(ERASE_COUNT), .WRITE_COUNT(WRITE_COUNT)) i_deepc_ctrl_assertions (
	.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .cycle_done_irq_flag(cycle_done_irq_flag), .array_erase(array_erase),
	.array_program(array_program), .array_bulk(array_bulk), .array_count(array_count), .busy(busy));

//--- deepc_cpu_model.sv
// Purpose: processor-side bus master for the control registers
// Assumes: write strobe held until the next task's edge; read strobe drops after one clock
// Notes:   idle data lines are inverted so stale values never look valid
module deepc_cpu_model
	import deepc_pkg::*;
(
	input  wire logic        sys_clk,   // clock
	input  wire logic [15:0] reg_rdata, // read data
	output logic      [1:0]  reg_addr,  // index
	output logic      [15:0] reg_wdata, // write data
	output logic             reg_wr,    // write strobe
	output logic             reg_rd     // read strobe
);
	initial
	begin
		reg_addr = ADDR_CONTROL;
		reg_wdata = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	task automatic wr(input logic [1:0] a, input logic [15:0] v);
		@(posedge sys_clk);
		reg_addr  <= a;
		reg_wdata <= v;
		reg_wr    <= 1'b1;
	endtask
	task automatic idle();
		@(posedge sys_clk);
		reg_wr    <= 1'b0;
		reg_wdata <= ~reg_wdata;
	endtask
	task automatic rd(input logic [1:0] a, output logic [15:0] v);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wr   <= 1'b0;
		reg_rd   <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask
	// keys go back to back, nothing can split them
	task automatic start(input logic [15:0] cfg);
		wr(ADDR_KEY, {8'h00, KEY_FIRST});
		wr(ADDR_KEY, {8'h00, KEY_SECOND});
		wr(ADDR_CONTROL, cfg | 16'h8000);
		idle();
		idle();
	endtask
endmodule

//--- deepc_ctrl_tb.sv
// Purpose: self-checking bench for the eeprom program/erase control block
// Assumes: reduced phase counts, array outputs sampled on the falling edge
// Notes:   phase lengths are counted in cycles, not checked against time
module deepc_ctrl_tb;
	import deepc_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int EC = 4;
	localparam int WC = 4;
	logic        sys_clk = 1'b0;
	logic        reset = 1'b1;
	logic        abort_reset = 1'b0;
	logic        tblwt_valid = 1'b0;
	logic [23:0] tblwt_addr = 24'h00_0000;
	logic [1:0]  reg_addr;
	logic [15:0] reg_wdata, reg_rdata;
	logic        reg_wr, reg_rd, cycle_done_irq_flag, array_erase, array_program, array_bulk, busy, bulk;
	logic [7:0]  array_word, word;
	logic [3:0]  array_count, cnt;
	int          n_mismatch = 0, n_tests = 0, ne = 0, np = 0, nd = 0;
	always #5 sys_clk = ~sys_clk;
	always @(negedge sys_clk)
	begin
		ne += array_erase;
		np += array_program;
		nd += cycle_done_irq_flag;
		if (busy === 1'b1)
		begin
			cnt = array_count;
			bulk = array_bulk;
			word = array_word;
		end
	end
	deepc_cpu_model i_deepc_cpu_model (.sys_clk(sys_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));
	deepc_ctrl #(.ERASE_COUNT(EC), .WRITE_COUNT(WC)) i_deepc_ctrl (.sys_clk(sys_clk), .reset(reset),
		.abort_reset(abort_reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .tblwt_valid(tblwt_valid), .tblwt_addr(tblwt_addr),
		.cycle_done_irq_flag(cycle_done_irq_flag), .array_erase(array_erase), .array_program(array_program),
		.array_bulk(array_bulk), .array_word(array_word), .array_count(array_count), .busy(busy));
	task automatic chk(input logic [15:0] g, input logic [15:0] x);
		n_tests++;
		if (g !== x)
		begin
			n_mismatch++;
			$display("unexpected at %0t: got %h want %h", $time, g, x);
		end
	endtask
	task automatic complete_run();
		if (n_mismatch == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic rd_chk(input logic [1:0] a, input logic [15:0] x);
		logic [15:0] v;
		i_deepc_cpu_model.rd(a, v);
		chk(v, x);
	endtask
	task automatic wait_busy(input logic v);
		for (int i = 0; i < 100 && busy !== v; i++)
			@(negedge sys_clk);
		chk({15'h0000, busy}, {15'h0000, v});
	endtask
	task automatic load(input logic [23:0] a);
		@(posedge sys_clk);
		tblwt_addr  <= a;
		tblwt_valid <= 1'b1;
		@(posedge sys_clk);
		tblwt_valid <= 1'b0;
	endtask
	task automatic op(input logic [15:0] cfg, input logic [23:0] a, input int xe, xp, xd, input logic [15:0] xc);
		int e0 = ne;
		int p0 = np;
		int d0 = nd;
		load(a);
		i_deepc_cpu_model.start(cfg);
		for (int i = 0; i < 100 && nd == d0; i++)
			@(negedge sys_clk);
		wait_busy(1'b0);
		chk(16'(ne - e0), 16'(xe));
		chk(16'(np - p0), 16'(xp));
		chk(16'(nd - d0), 16'(xd));
		rd_chk(ADDR_CONTROL, xc);
	endtask
	task automatic t_config();
		rd_chk(ADDR_CONTROL, CONTROL_RESET);
		rd_chk(ADDR_KEY, 16'h0000);
		i_deepc_cpu_model.wr(ADDR_CONTROL, 16'hFFFF);
		i_deepc_cpu_model.idle();
		rd_chk(ADDR_CONTROL, 16'h507F);
	endtask
	task automatic t_refuse();
		int e0 = ne;
		i_deepc_cpu_model.wr(ADDR_KEY, 16'h0055);
		i_deepc_cpu_model.wr(ADDR_KEY, 16'h0012);
		i_deepc_cpu_model.wr(ADDR_KEY, 16'h00AA);
		i_deepc_cpu_model.wr(ADDR_CONTROL, 16'hC058);
		i_deepc_cpu_model.idle();
		repeat (8) @(posedge sys_clk);
		chk(16'(ne - e0), 16'h0000);
		rd_chk(ADDR_CONTROL, 16'h4058);
		op(16'h0058, EEPROM_BASE, 0, 0, 0, 16'h2058);
		op(16'h4058, 24'h00_1000, 0, 0, 0, 16'h2058);
	endtask
	task automatic t_abort();
		load(EEPROM_BASE);
		i_deepc_cpu_model.start(16'h4008);
		wait_busy(1'b1);
		@(posedge sys_clk);
		abort_reset <= 1'b1;
		repeat (2) @(posedge sys_clk);
		abort_reset <= 1'b0;
		wait_busy(1'b0);
		rd_chk(ADDR_CONTROL, 16'h2008);
	endtask
	task automatic t_erase();
		logic [15:0] c [3] = '{16'h405A, 16'h4059, 16'h4058};
		logic [3:0]  w [3] = '{4'h8, 4'h4, 4'h1};
		for (int k = 0; k < 3; k++)
		begin
			op(c[k], EEPROM_BASE + 24'h00_0020, EC, 0, 1, c[k] & 16'h107F);
			chk({12'h000, cnt}, {12'h000, w[k]});
			chk({8'h00, word}, 16'h0010);
		end
	endtask
	task automatic t_bulk();
		logic [15:0] c [2] = '{16'h4050, 16'h4053};
		for (int k = 0; k < 2; k++)
		begin
			op(c[k], 24'h00_0000, EC, 0, 1, c[k] & 16'h107F);
			chk({15'h0000, bulk}, 16'h0001);
			chk({12'h000, cnt}, 16'h0000);
		end
	endtask
	task automatic t_write();
		op(16'h400A, EEPROM_BASE + 24'h00_0002, EC, WC, 1, 16'h000A);
		chk({8'h00, word}, 16'h0001);
		op(16'h500B, EEPROM_BASE + 24'h00_01FE, 0, WC, 1, 16'h100B);
		chk({8'h00, word}, 16'h00FF);
	endtask
	initial
	begin
		repeat (6) @(posedge sys_clk);
		reset <= 1'b0;
		t_config();
		t_refuse();
		t_abort();
		t_erase();
		t_bulk();
		t_write();
		complete_run();
	end
	initial
	begin
		#200us;
		n_mismatch++;
		complete_run();
	end
endmodule
